//--- hw/thermal_monitor_pkg.sv
package thermal_monitor_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int CONV_TIME_US = 100000;
   localparam int CONV_CYCLES_DEF = CONV_TIME_US * CLK_MHZ;
   localparam int CONV_W = 25;

   // ----------------------------------------------------------------
   // Serial target address and register pointer values
   // ----------------------------------------------------------------
   localparam logic [3:0] TARGET_ADDR_HI = 4'h9;
   localparam logic [1:0] PTR_TEMP = 2'h0;
   localparam logic [1:0] PTR_CONF = 2'h1;
   localparam logic [1:0] PTR_HYST = 2'h2;
   localparam logic [1:0] PTR_OVER = 2'h3;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // ----------------------------------------------------------------
   // Settings register fields and power-up values
   // ----------------------------------------------------------------
   localparam int STOP_BIT = 0;
   localparam int MODE_BIT = 1;
   localparam int POL_BIT = 2;
   localparam logic [7:0] CONF_RST = 8'h00;
   localparam logic [8:0] OVER_RST = 9'h0A0;
   localparam logic [8:0] HYST_RST = 9'h096;
   localparam logic [1:0] PTR_RST = 2'h0;
   localparam logic [10:0] TEMP_RST = 11'h000;

   // ----------------------------------------------------------------
   // APB map
   // ----------------------------------------------------------------
   localparam logic [7:0] SAMPLE_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam int ST_STOP = 0;
   localparam int ST_ALARM = 1;
   localparam int ST_HOT = 2;
   localparam int ST_TEMP_LSB = 16;

   // Synchroniser idle value: address pins low, drop low, lines high
   localparam logic [5:0] SYNC_RST = 6'h03;

   typedef enum logic [2:0] {
      LINK_IDLE = 3'h0,
      LINK_RX = 3'h1,
      LINK_ACK_OUT = 3'h3,
      LINK_TX = 3'h2,
      LINK_ACK_IN = 3'h6
   } link_state_e;

endpackage

//--- hw/serial_line_sampler.sv
`timescale 1ns/1ps
module serial_line_sampler
   import thermal_monitor_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic [5:0] pins_i,
   output logic scl_lvl_o,
   output logic sda_lvl_o,
   output logic scl_rise_o,
   output logic scl_fall_o,
   output logic start_o,
   output logic stop_o,
   output logic drop_o,
   output logic [2:0] addr_o
);

   typedef struct packed {
      logic [5:0] s1;
      logic [5:0] s2;
      logic scl_d;
      logic sda_d;
   } samp_s;

   samp_s st_reg;
   samp_s st_next;

   // ----------------------------------------------------------------
   // Two-stage synchroniser; only s2 and its delayed copy are decoded
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.s1 = pins_i;
      st_next.s2 = st_reg.s1;
      st_next.scl_d = st_reg.s2[0];
      st_next.sda_d = st_reg.s2[1];
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         st_reg <= '{s1: SYNC_RST, s2: SYNC_RST, scl_d: 1'b1, sda_d: 1'b1};
      end else begin
         st_reg <= st_next;
      end
   end

   // Edge and bus-condition decode
   assign scl_lvl_o = st_reg.s2[0];
   assign sda_lvl_o = st_reg.s2[1];
   assign scl_rise_o = st_reg.s2[0] & ~st_reg.scl_d;
   assign scl_fall_o = ~st_reg.s2[0] & st_reg.scl_d;
   assign start_o = st_reg.s2[0] & st_reg.scl_d & st_reg.sda_d & ~st_reg.s2[1];
   assign stop_o = st_reg.s2[0] & st_reg.scl_d & ~st_reg.sda_d & st_reg.s2[1];
   assign addr_o = st_reg.s2[4:2];
   assign drop_o = st_reg.s2[5];

endmodule

//--- hw/thermal_monitor_serial_port.sv
`timescale 1ns/1ps
//------------------------------------------------------------------
// Function
// - Stop bit set enters stopped mode
// - Stop bit cleared resumes periodic conversions
// - Stopped: no conversions, serial port still works
// - Stopping leaves alarm output unchanged
// - Power-up: normal, comparator, low, 80/75
// - Power-up pointer is zero
// - Supply drop restores all defaults
// - Host clocks; nine pulses per byte
// - Data changes only while clock low
// - Stop frees the bus
// - Direction bit: low write, high read
// - Device acknowledges by driving low
// - Host ack brings second read byte
// - Final slot released as not-acknowledge
// - Write: host drives except device ack
// - Read: device drives except host ack
// - Reading is 11 bits, 0.125 degree
// - Settings bit 2 sets alarm polarity
// - Settings bit 1 sets alarm mode
// - Interrupt alarm held until register read
// - Compare top nine reading bits to limits
//------------------------------------------------------------------
module thermal_monitor_serial_port
   import thermal_monitor_pkg::*;
#(
   parameter int unsigned CONV_CYCLES = CONV_CYCLES_DEF
)(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic address_select_pin_0_i,
   input wire logic address_select_pin_1_i,
   input wire logic address_select_pin_2_i,
   input wire logic supply_drop_i,
   output logic thermal_alarm_output_o,
   output logic thermal_alarm_output_oe_o,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o
);

   typedef struct packed {
      link_state_e state;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic done;
      logic is_addr;
      logic rd;
      logic first;
      logic bidx;
      logic [1:0] ptr;
      logic [7:0] conf;
      logic [8:0] over;
      logic [8:0] hyst;
      logic [10:0] temp;
      logic [10:0] sample;
      logic hot;
      logic alarm;
      logic sda_oe;
      logic alarm_oe;
      logic [CONV_W-1:0] conv_cnt;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } port_s;

   port_s st_reg;
   port_s st_next;

   logic scl_lvl, sda_s, scl_rise, scl_fall, start_p, stop_p, drop_s;
   logic [2:0] addr_s;
   logic addr_match, rd_clr, conv_end, over_lim, under_lim;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Power-up image; also reloaded on a supply drop
   function automatic port_s reset_state();
      port_s s;
      s = '0;
      s.state = LINK_IDLE;
      s.ptr = PTR_RST;
      s.conf = CONF_RST;
      s.over = OVER_RST;
      s.hyst = HYST_RST;
      s.temp = TEMP_RST;
      s.alarm_oe = CONF_RST[POL_BIT];
      return s;
   endfunction

   // Byte presented for a read of register p, byte idx
   function automatic logic [7:0] reg_byte(input logic [1:0] p, input logic idx,
                                           input port_s s);
      logic [7:0] b;
      b = 8'h00;
      case (p)
         PTR_TEMP: b = idx ? {s.temp[2:0], 5'h00} : s.temp[10:3];
         PTR_CONF: b = s.conf;
         PTR_HYST: b = idx ? {s.hyst[0], 7'h00} : s.hyst[8:1];
         default: b = idx ? {s.over[0], 7'h00} : s.over[8:1];
      endcase
      return b;
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers and bus-condition detection
   // ----------------------------------------------------------------
   serial_line_sampler u_sampler (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .pins_i({supply_drop_i, address_select_pin_2_i, address_select_pin_1_i,
               address_select_pin_0_i, sda_i, scl_i}),
      .scl_lvl_o(scl_lvl),
      .sda_lvl_o(sda_s),
      .scl_rise_o(scl_rise),
      .scl_fall_o(scl_fall),
      .start_o(start_p),
      .stop_o(stop_p),
      .drop_o(drop_s),
      .addr_o(addr_s)
   );

   // Address compare and the read that releases an interrupt alarm
   assign addr_match = st_reg.sh[7:1] == {TARGET_ADDR_HI, addr_s};
   assign rd_clr = scl_fall && st_reg.state == LINK_RX && st_reg.done &&
                   st_reg.is_addr && addr_match && st_reg.sh[0];
   // Conversion timer ends only while running; limits use 9 MSBs
   assign conv_end = !st_reg.conf[STOP_BIT] &&
                     st_reg.conv_cnt == CONV_W'(CONV_CYCLES - 1);
   assign over_lim = $signed(st_reg.sample[10:2]) > $signed(st_reg.over);
   assign under_lim = $signed(st_reg.sample[10:2]) < $signed(st_reg.hyst);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      // Counter freezes in stopped mode, so no reading is taken
      if (!st_reg.conf[STOP_BIT]) begin
         st_next.conv_cnt = conv_end ? '0 : st_reg.conv_cnt + 1'b1;
      end
      // Read clears a held interrupt; a same-cycle trip wins below
      if (rd_clr && st_reg.conf[MODE_BIT]) begin
         st_next.alarm = 1'b0;
      end
      if (conv_end) begin
         st_next.temp = st_reg.sample;
         if (!st_reg.hot && over_lim) begin
            st_next.hot = 1'b1;
            st_next.alarm = 1'b1;
         end else if (st_reg.hot && under_lim) begin
            st_next.hot = 1'b0;
            st_next.alarm = st_reg.conf[MODE_BIT];
         end
      end

      // Serial target; the pin only ever moves after a clock fall
      case (st_reg.state)
         LINK_RX: begin
            if (scl_rise && !st_reg.done) begin
               st_next.sh = {st_reg.sh[6:0], sda_s};
               st_next.cnt = st_reg.cnt + 1'b1;
               st_next.done = st_reg.cnt == BYTE_BITS - 4'h1;
            end
            if (scl_fall && st_reg.done) begin
               st_next.done = 1'b0;
               st_next.cnt = 4'h0;
               st_next.is_addr = 1'b0;
               if (st_reg.is_addr) begin
                  if (addr_match) begin
                     st_next.rd = st_reg.sh[0];
                     st_next.first = ~st_reg.sh[0];
                     st_next.bidx = 1'b0;
                     st_next.sda_oe = 1'b1;
                     st_next.state = LINK_ACK_OUT;
                     if (st_reg.sh[0]) begin
                        st_next.sh = reg_byte(st_reg.ptr, 1'b0, st_reg);
                     end
                  end else begin
                     st_next.state = LINK_IDLE;
                  end
               end else begin
                  if (st_reg.first) begin
                     st_next.ptr = st_reg.sh[1:0];
                  end else begin
                     st_next.bidx = ~st_reg.bidx;
                     case (st_reg.ptr)
                        PTR_CONF: st_next.conf = st_reg.sh;
                        PTR_HYST: begin
                           if (st_reg.bidx) st_next.hyst[0] = st_reg.sh[7];
                           else st_next.hyst[8:1] = st_reg.sh;
                        end
                        PTR_OVER: begin
                           if (st_reg.bidx) st_next.over[0] = st_reg.sh[7];
                           else st_next.over[8:1] = st_reg.sh;
                        end
                        default: st_next.conf = st_reg.conf;
                     endcase
                  end
                  st_next.first = 1'b0;
                  st_next.sda_oe = 1'b1;
                  st_next.state = LINK_ACK_OUT;
               end
            end
         end
         LINK_ACK_OUT: begin
            if (scl_fall) begin
               st_next.cnt = 4'h0;
               if (st_reg.rd) begin
                  st_next.state = LINK_TX;
                  st_next.sda_oe = ~st_reg.sh[7];
               end else begin
                  st_next.state = LINK_RX;
                  st_next.sda_oe = 1'b0;
               end
            end
         end
         LINK_TX: begin
            if (scl_rise) begin
               st_next.cnt = st_reg.cnt + 1'b1;
            end
            if (scl_fall) begin
               if (st_reg.cnt == BYTE_BITS) begin
                  st_next.state = LINK_ACK_IN;
                  st_next.sda_oe = 1'b0;
               end else begin
                  st_next.sh = {st_reg.sh[6:0], 1'b0};
                  st_next.sda_oe = ~st_reg.sh[6];
               end
            end
         end
         LINK_ACK_IN: begin
            if (scl_rise) begin
               if (!sda_s) begin
                  st_next.bidx = ~st_reg.bidx;
                  st_next.sh = reg_byte(st_reg.ptr, ~st_reg.bidx, st_reg);
                  st_next.done = 1'b1;
               end else begin
                  st_next.state = LINK_IDLE;
               end
            end
            if (scl_fall && st_reg.done) begin
               st_next.done = 1'b0;
               st_next.cnt = 4'h0;
               st_next.state = LINK_TX;
               st_next.sda_oe = ~st_reg.sh[7];
            end
         end
         default: st_next.state = LINK_IDLE;
      endcase
      // A start (or repeated start) always rearms address reception
      if (start_p) begin
         st_next.state = LINK_RX;
         st_next.is_addr = 1'b1;
         st_next.cnt = 4'h0;
         st_next.done = 1'b0;
         st_next.sda_oe = 1'b0;
      end
      if (stop_p) begin
         st_next.state = LINK_IDLE;
         st_next.sda_oe = 1'b0;
      end

      // APB slave: answer one cycle into the access phase
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
      if (psel_i && penable_i && !st_reg.pready) begin
         st_next.pready = 1'b1;
         case (paddr_i)
            SAMPLE_OFS: st_next.prdata = {21'h000000, st_reg.sample};
            STATUS_OFS: begin
               st_next.prdata = 32'h00000000;
               st_next.prdata[ST_STOP] = st_reg.conf[STOP_BIT];
               st_next.prdata[ST_ALARM] = st_reg.alarm;
               st_next.prdata[ST_HOT] = st_reg.hot;
               st_next.prdata[ST_TEMP_LSB +: 11] = st_reg.temp;
            end
            default: begin
               st_next.prdata = 32'h00000000;
               st_next.pslverr = 1'b1;
            end
         endcase
      end
      // Write lands on the edge that samples pready high
      if (psel_i && penable_i && st_reg.pready && pwrite_i && paddr_i == SAMPLE_OFS) begin
         st_next.sample = pwdata_i[10:0];
      end

      // Open drain: pull low when the level wanted is low
      st_next.alarm_oe = st_next.alarm ^ st_next.conf[POL_BIT];
      if (drop_s) begin
         st_next = reset_state();
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         st_reg <= reset_state();
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign sda_o = 1'b0;
   assign sda_oe_o = st_reg.sda_oe;
   assign thermal_alarm_output_o = 1'b0;
   assign thermal_alarm_output_oe_o = st_reg.alarm_oe;
   assign prdata_o = st_reg.prdata;
   assign pready_o = st_reg.pready;
   assign pslverr_o = st_reg.pslverr;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   conv_halt_a: assert property (@(posedge sys_clk_i) disable iff (reset_i || drop_s)
      st_reg.conf[STOP_BIT] |=> $stable(st_reg.conv_cnt) && $stable(st_reg.temp))
      else $error("conversion advanced while stopped");
   alarm_hold_a: assert property (@(posedge sys_clk_i) disable iff (reset_i || drop_s)
      st_reg.conf[STOP_BIT] && !rd_clr |=> $stable(st_reg.alarm))
      else $error("alarm changed in stopped mode");
   alarm_pin_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      thermal_alarm_output_oe_o == (st_reg.alarm ^ st_reg.conf[POL_BIT]))
      else $error("alarm pin polarity wrong");
   ack_drive_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      rd_clr || (scl_fall && st_reg.state == LINK_RX && st_reg.done && !st_reg.is_addr
                 && !start_p && !stop_p && !drop_s) |=> sda_oe_o [*2])
      else $error("device acknowledge not driven");
   sda_stable_a: assert property (@(posedge sys_clk_i) disable iff (reset_i || drop_s)
      scl_lvl && $past(scl_lvl) && !$past(start_p) && !$past(stop_p) |-> $stable(sda_oe_o))
      else $error("data moved while clock high");
   stop_free_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      stop_p |=> st_reg.state == LINK_IDLE && !sda_oe_o)
      else $error("bus not freed after stop");
   conv_load_a: assert property (@(posedge sys_clk_i) disable iff (reset_i || drop_s)
      conv_end |=> st_reg.temp == $past(st_reg.sample) && st_reg.conv_cnt == '0)
      else $error("reading not updated at conversion end");
   rd_clear_a: assert property (@(posedge sys_clk_i) disable iff (reset_i || drop_s)
      rd_clr && !conv_end && st_reg.conf[MODE_BIT] |=> !st_reg.alarm)
      else $error("interrupt alarm not cleared by read");
   comp_trip_a: assert property (@(posedge sys_clk_i) disable iff (reset_i || drop_s)
      conv_end && !st_reg.hot && over_lim |=> st_reg.alarm && st_reg.hot)
      else $error("over limit did not trip alarm");
   drop_dflt_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      drop_s |=> st_reg.conf == CONF_RST && st_reg.over == OVER_RST &&
                 st_reg.hyst == HYST_RST && st_reg.ptr == PTR_RST)
      else $error("defaults not restored after supply drop");
   nack_end_a: assert property (@(posedge sys_clk_i) disable iff (reset_i || drop_s)
      st_reg.state == LINK_ACK_IN && scl_rise && sda_s && !start_p && !stop_p
      |=> st_reg.state == LINK_IDLE && !sda_oe_o)
      else $error("not-acknowledge did not end read");

   read_ack_c: cover property (@(posedge sys_clk_i) disable iff (reset_i) rd_clr);
   conf_wr_c: cover property (@(posedge sys_clk_i) disable iff (reset_i)
      st_reg.conf != $past(st_reg.conf));
   alarm_up_c: cover property (@(posedge sys_clk_i) disable iff (reset_i)
      $rose(st_reg.alarm));
   second_byte_c: cover property (@(posedge sys_clk_i) disable iff (reset_i)
      st_reg.state == LINK_ACK_IN && scl_rise && !sda_s);

endmodule

//--- test/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model (
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o,
   output logic [7:0] glitch_o
);
   // Both lines released at rest, so the first transfer opens on an idle bus
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      glitch_o = 8'h00;
   end

   // ----------------------------------------------------------------
   // Bus conditions
   // ----------------------------------------------------------------
   // Releases data first, so the same task also serves as repeated start
   // Pins move by non-blocking assignment: calls begin on a clock edge,
   // and the sampling flops must see the old level at that edge
   task automatic start_cond();
      #8 sda_o <= 1'b1;
      #8 scl_o <= 1'b1;
      #8 sda_o <= 1'b0;
      #8 scl_o <= 1'b0;
   endtask

   task automatic stop_cond();
      #8 sda_o <= 1'b0;
      #8 scl_o <= 1'b1;
      #8 sda_o <= 1'b1;
      #16;
   endtask

   // One pulse; data set mid-low, sampled twice while high to catch glitches
   task automatic bit_io(input logic b, output logic r);
      #8 sda_o <= b;
      #8 scl_o <= 1'b1;
      #4 r = sda_i;
      #8 if (sda_i !== r) glitch_o = glitch_o + 8'h01;
      #4 scl_o <= 1'b0;
   endtask

   // Eight bits, then the slot left released for the device
   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, ack);
   endtask

   task automatic read_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
   import thermal_monitor_pkg::*;
   localparam int CONV = 100;
   localparam int PW = 2 * CONV + 20;
   typedef struct packed {
      logic [1:0] p;
      logic [1:0] n;
      logic [15:0] wr;
      logic [15:0] ex;
   } row_s;
   logic sys_clk_i, reset_i, scl, host_sda, dev_sda, dev_oe, drop, alarm, alarm_oe;
   logic psel, penable, pwrite, pready, pslverr, ack, err;
   logic [7:0] paddr, glitches;
   logic [31:0] pwdata, prdata, rd, got;
   logic [2:0] pins;
   int miscompares, n_checks;
   // Open-drain data wire: low if either party pulls
   wire sda_line = host_sda & (dev_oe ? dev_sda : 1'b1);
   row_s rows [10] = '{
      '{PTR_CONF, 2'h0, 16'h0000, 16'h0000},
      '{PTR_HYST, 2'h0, 16'h0000, 16'h4B00},
      '{PTR_OVER, 2'h0, 16'h0000, 16'h5000},
      '{PTR_HYST, 2'h2, 16'h3280, 16'h3280},
      '{PTR_OVER, 2'h2, 16'h01FF, 16'h0180},
      '{PTR_CONF, 2'h1, 16'hF800, 16'hF8F8},
      '{PTR_TEMP, 2'h2, 16'hFFFF, 16'h0000},
      '{PTR_CONF, 2'h1, 16'h0000, 16'h0000},
      '{PTR_HYST, 2'h2, 16'h4B00, 16'h4B00},
      '{PTR_OVER, 2'h2, 16'h5000, 16'h5000}
   };

   thermal_monitor_serial_port #(.CONV_CYCLES(CONV)) i_dut (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .scl_i(scl),
      .sda_i(sda_line),
      .sda_o(dev_sda),
      .sda_oe_o(dev_oe),
      .address_select_pin_0_i(pins[0]),
      .address_select_pin_1_i(pins[1]),
      .address_select_pin_2_i(pins[2]),
      .supply_drop_i(drop),
      .thermal_alarm_output_o(alarm),
      .thermal_alarm_output_oe_o(alarm_oe),
      .psel_i(psel),
      .penable_i(penable),
      .pwrite_i(pwrite),
      .paddr_i(paddr),
      .pwdata_i(pwdata),
      .prdata_o(prdata),
      .pready_o(pready),
      .pslverr_o(pslverr)
   );

   serial_host_model i_host (.sda_i(sda_line), .scl_o(scl), .sda_o(host_sda), .glitch_o(glitches));

   // 250 MHz system clock
   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic check_word(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %0t: word %h expected %h", $time, g, e);
      end
   endtask

   task automatic check_bit(input logic g, input logic e);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %0t: bit %b expected %b", $time, g, e);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   // Starts on an edge of its own, so back-to-back calls never collide
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) miscompares++;
   endtask

   task automatic wr_reg(input logic [1:0] p, input logic [1:0] n, input logic [15:0] d);
      i_host.start_cond();
      i_host.write_byte({TARGET_ADDR_HI, pins, 1'b0}, ack);
      check_bit(ack, 1'b0);
      i_host.write_byte({6'h00, p}, ack);
      for (int i = 0; i < n; i++) begin
         i_host.write_byte(i == 0 ? d[15:8] : d[7:0], ack);
         check_bit(ack, 1'b0);
      end
      i_host.stop_cond();
   endtask

   task automatic rd_reg(input logic set_ptr, input logic [1:0] p);
      logic [7:0] b0, b1;
      if (set_ptr) begin
         i_host.start_cond();
         i_host.write_byte({TARGET_ADDR_HI, pins, 1'b0}, ack);
         i_host.write_byte({6'h00, p}, ack);
      end
      i_host.start_cond();
      i_host.write_byte({TARGET_ADDR_HI, pins, 1'b1}, ack);
      check_bit(ack, 1'b0);
      i_host.read_byte(1'b0, b0);
      i_host.read_byte(1'b1, b1);
      i_host.stop_cond();
      got = {16'h0000, b0, b1};
   endtask

   // Load a converter result and let at least one conversion end pass
   task automatic conv_to(input logic [10:0] s);
      apb(1'b1, SAMPLE_OFS, {21'h000000, s});
      repeat (PW) @(posedge sys_clk_i);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      reset_i = 1'b1;
      {psel, penable, pwrite, drop} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      pins = 3'h5;
      miscompares = 0;
      n_checks = 0;
      repeat (5) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      check_bit(alarm_oe, 1'b0);
      check_bit(dev_oe, 1'b0);
      apb(1'b0, STATUS_OFS, 32'h00000000);
      check_word(rd, 32'h00000000);
      rd_reg(1'b0, PTR_TEMP);
      check_word(got, 32'h00000000);
      foreach (rows[i]) begin
         if (rows[i].n != 2'h0) wr_reg(rows[i].p, rows[i].n, rows[i].wr);
         rd_reg(1'b1, rows[i].p);
         check_word(got, {16'h0000, rows[i].ex});
      end
      // Limit compare uses only the nine top bits, with hysteresis
      conv_to(11'h283);
      check_bit(alarm_oe, 1'b0);
      conv_to(11'h284);
      check_bit(alarm_oe, 1'b1);
      rd_reg(1'b1, PTR_TEMP);
      check_word(got, 32'h00005080);
      apb(1'b0, STATUS_OFS, 32'h00000000);
      check_word(rd & 32'h07FF0003, 32'h02840002);
      conv_to(11'h25C);
      check_bit(alarm_oe, 1'b1);
      conv_to(11'h257);
      check_bit(alarm_oe, 1'b0);
      // Stopped: conversions freeze, alarm holds its level, serial port keeps working
      conv_to(11'h284);
      wr_reg(PTR_CONF, 2'h1, 16'h0100);
      apb(1'b0, STATUS_OFS, 32'h00000000);
      check_bit(rd[ST_STOP], 1'b1);
      conv_to(11'h000);
      check_bit(alarm_oe, 1'b1);
      rd_reg(1'b1, PTR_TEMP);
      check_word(got, 32'h00005080);
      wr_reg(PTR_CONF, 2'h1, 16'h0000);
      repeat (PW) @(posedge sys_clk_i);
      rd_reg(1'b1, PTR_TEMP);
      check_word(got, 32'h00000000);
      check_bit(alarm_oe, 1'b0);
      wr_reg(PTR_CONF, 2'h1, 16'h0400);
      check_bit(alarm_oe, 1'b1);
      // Interrupt mode holds the alarm until a register read
      wr_reg(PTR_CONF, 2'h1, 16'h0200);
      conv_to(11'h284);
      check_bit(alarm_oe, 1'b1);
      repeat (PW) @(posedge sys_clk_i);
      check_bit(alarm_oe, 1'b1);
      rd_reg(1'b1, PTR_CONF);
      check_bit(alarm_oe, 1'b0);
      // Foreign address is left unanswered; an unmapped APB offset answers with an error
      i_host.start_cond();
      i_host.write_byte({TARGET_ADDR_HI, ~pins, 1'b0}, ack);
      check_bit(ack, 1'b1);
      i_host.stop_cond();
      apb(1'b0, 8'h08, 32'h00000000);
      check_bit(err, 1'b1);
      // Supply dip brings back every power-up value
      wr_reg(PTR_OVER, 2'h2, 16'h1000);
      @(posedge sys_clk_i);
      drop <= 1'b1;
      repeat (8) @(posedge sys_clk_i);
      drop <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      rd_reg(1'b0, PTR_TEMP);
      check_word(got, 32'h00000000);
      rd_reg(1'b1, PTR_OVER);
      check_word(got, 32'h00005000);
      rd_reg(1'b1, PTR_CONF);
      check_word(got, 32'h00000000);
      check_word({24'h000000, glitches}, 32'h00000000);
      check_word({30'h0000000, alarm, dev_sda}, 32'h00000000);
      tally_and_finish();
   end

   // Run needs well under 100 us; a hang is cut off here
   initial begin
      #300000;
      miscompares++;
      tally_and_finish();
   end
endmodule
